// File: hdl/pcc_cfg.svh
// constants for the pulse counter comparator
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH
`define PCC_CNT_W 23
`define PCC_CNT_MAX 23'h7FFFFF
`define PCC_NREG_B 16
`define PCC_NPART 17
`define PCC_OUT_W 8
`define PCC_ADDR_W 12
// register byte offsets
`define PCC_OFS_CTRL 12'h000
`define PCC_OFS_STAT 12'h004
`define PCC_OFS_PRESET 12'h008
`define PCC_OFS_COUNT 12'h00C
`define PCC_OFS_CMP0 12'h010
`define PCC_OFS_CMP1 12'h014
`define PCC_OFS_CMP2 12'h018
`define PCC_OFS_BREG 12'h040
`define PCC_OFS_PART 12'h080
// control bit positions
`define PCC_CTL_MODE 0
`define PCC_CTL_POLA 1
`define PCC_CTL_POLB 2
`define PCC_CTL_POLC 3
`define PCC_CTL_SYNC 4
`define PCC_CTL_PMSEL 5
`define PCC_CTL_W 6
`endif

// File: hdl/pcc_pkg.sv
// types for the pulse counter comparator
`include "pcc_cfg.svh"
package pcc_pkg;
  typedef enum logic [1:0] {
    PCC_MODE_A = 2'h0,
    PCC_MODE_B = 2'h1
  } pcc_mode_t;
  typedef logic [`PCC_CNT_W-1:0] pcc_cnt_t;
endpackage

// File: hdl/pcc_sync2.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pcc_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pccs_st_t;
  pccs_st_t st_r;
  pccs_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_out = st_r.s2;
endmodule

// File: hdl/pcc_decoder.sv
// pulse decoder: quadrature x4 or up/down pulses to count steps
`timescale 1ns/100ps
module pcc_decoder (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic pm_sel_in,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  output logic step_up_out,
  output logic step_dn_out
);
  typedef struct packed {
    logic a;
    logic b;
  } pccd_st_t;
  pccd_st_t st_r;
  pccd_st_t st_nxt;
  logic ea;
  logic eb;
  always_comb begin
    st_nxt = st_r;
    st_nxt.a = phase_a_in;
    st_nxt.b = phase_b_in;
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign ea = phase_a_in ^ st_r.a;
  assign eb = phase_b_in ^ st_r.b;
  // quadrature: each edge of one phase while the other holds, direction from which phase leads; pulse mode: rising edges only, up on A, down on B
  always_comb begin
    step_up_out = 1'b0;
    step_dn_out = 1'b0;
    if (pm_sel_in) begin
      step_up_out = phase_a_in & ~st_r.a & ~(phase_b_in & ~st_r.b);
      step_dn_out = phase_b_in & ~st_r.b & ~(phase_a_in & ~st_r.a);
    end else if (ea ^ eb) begin
      step_up_out = ea ? (phase_a_in ^ phase_b_in) : ~(phase_a_in ^ phase_b_in);
      step_dn_out = ~step_up_out;
    end
  end
endmodule

// File: hdl/pcc_top.sv
// pulse counter with mode A / mode B compare outputs and APB registers
// Notes on behaviour
// - count detector pulses from the external pulse generator as position feedback
// - a single binary up/down counter
// - count spans zero to 8,388,607, 23 bits unsigned
// - host loads a preset value into the counter and reads the count
// - two modes: A three-register compare, B sixteen-register partitions
// - mode A has three 23-bit compare registers set by the host
// - mode A drives three compare outputs, one per register
// - polarity 0: output high while count exceeds register, else low
// - polarity 1: output inverted, low while count exceeds register
// - mode B has sixteen 23-bit compare registers numbered 0 to 15
// - mode B drives eight partition output bits
// - scan from register 0 to first value at least count, output its byte
// - quadrature counts each edge of one phase while the other holds, up when A leads, down when B leads
// - sync request with marker enable closed loads preset on first marker rise
// - count stop contact closed suspends counting
`timescale 1ns/100ps
`include "pcc_cfg.svh"
module pcc_top
  import pcc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic marker_in,
  input wire logic marker_enable_contact_in,
  input wire logic count_stop_contact_in,
  output logic compare_out_a_out,
  output logic compare_out_b_out,
  output logic compare_out_c_out,
  output logic [`PCC_OUT_W-1:0] partition_out_out,
  output logic marker_hold_out
);

////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [`PCC_CTL_W-1:0] ctrl;
    pcc_cnt_t cnt;
    pcc_cnt_t preset;
    pcc_cnt_t [2:0] cmp_abc;
    pcc_cnt_t [`PCC_NREG_B-1:0] cmp_b;
    logic [`PCC_NPART-1:0][`PCC_OUT_W-1:0] part;
    logic mk_d;
    logic mk_hold;
    logic [2:0] cmp_o;
    logic [`PCC_OUT_W-1:0] part_o;
    logic [31:0] rdata;
  } pcc_st_t;

  pcc_st_t st_r;
  pcc_st_t st_nxt;
  logic [4:0] pins_s;
  logic step_up;
  logic step_dn;
  logic marker_s;
  logic mkena_s;
  logic stop_s;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic [`PCC_NREG_B-1:0] ge_vec;
  logic [`PCC_NREG_B:0] first_vec;
  logic [`PCC_OUT_W-1:0] part_sel;
  logic [31:0] rd_mux;
  logic [`PCC_ADDR_W-1:0] bidx;
  logic [`PCC_ADDR_W-1:0] pidx;

////////////////////////////////////////////////////////////////////////////////
  // pin inputs pass two flops
  pcc_sync2 #(
    .W(5)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .d_in({phase_a_in, phase_b_in, marker_in, marker_enable_contact_in,
      count_stop_contact_in}),
    .q_out(pins_s)
  );
  assign marker_s = pins_s[2];
  assign mkena_s = pins_s[1];
  assign stop_s = pins_s[0];

  // detector pulses to count steps
  pcc_decoder u_dec (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .pm_sel_in(st_r.ctrl[`PCC_CTL_PMSEL]),
    .phase_a_in(pins_s[4]),
    .phase_b_in(pins_s[3]),
    .step_up_out(step_up),
    .step_dn_out(step_dn)
  );

////////////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states; read data captured in the setup phase
  // so that it stands at the access edge
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign bidx = (paddr - `PCC_OFS_BREG) >> 2;
  assign pidx = (paddr - `PCC_OFS_PART) >> 2;
  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    rd_mux = 32'h0;
    addr_ok = 1'b1;
    if (paddr[1:0] != 2'h0) begin
      addr_ok = 1'b0;
    end else if (paddr == `PCC_OFS_CTRL) begin
      rd_mux = 32'(st_r.ctrl);
    end else if (paddr == `PCC_OFS_STAT) begin
      rd_mux = 32'({st_r.part_o, st_r.mk_hold, st_r.cmp_o});
    end else if (paddr == `PCC_OFS_PRESET) begin
      rd_mux = 32'(st_r.preset);
    end else if (paddr == `PCC_OFS_COUNT) begin
      rd_mux = 32'(st_r.cnt);
    end else if (paddr == `PCC_OFS_CMP0) begin
      rd_mux = 32'(st_r.cmp_abc[0]);
    end else if (paddr == `PCC_OFS_CMP1) begin
      rd_mux = 32'(st_r.cmp_abc[1]);
    end else if (paddr == `PCC_OFS_CMP2) begin
      rd_mux = 32'(st_r.cmp_abc[2]);
    end else if (paddr >= `PCC_OFS_BREG && bidx < `PCC_NREG_B) begin
      rd_mux = 32'(st_r.cmp_b[bidx[3:0]]);
    end else if (paddr >= `PCC_OFS_PART && pidx < `PCC_NPART) begin
      rd_mux = 32'(st_r.part[pidx[4:0]]);
    end else begin
      addr_ok = 1'b0;
    end
  end
  assign prdata = st_r.rdata;

////////////////////////////////////////////////////////////////////////////////
  // mode B partition search: first register whose value is at least the count
  genvar gi;
  generate
    for (gi = 0; gi < `PCC_NREG_B; gi++) begin : g_ge
      assign ge_vec[gi] = (st_r.cmp_b[gi] >= st_r.cnt);
    end
  endgenerate
  assign first_vec = {1'b1, ge_vec} & ~({1'b1, ge_vec} - 17'h1) ;

  always_comb begin
    part_sel = '0;
    for (int i = 0; i < `PCC_NPART; i++) begin
      if (first_vec[i]) begin
        part_sel = part_sel | st_r.part[i];
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.mk_d = marker_s;
    st_nxt.rdata = rd_acc ? rd_mux : st_r.rdata;
    // single up/down counter, held by the stop contact
    if (!stop_s) begin
      if (step_up) begin
        st_nxt.cnt = st_r.cnt + 23'h1;
      end else if (step_dn) begin
        st_nxt.cnt = st_r.cnt - 23'h1;
      end
    end
    // marker sync: first marker rise loads the preset
    if (!st_r.ctrl[`PCC_CTL_SYNC]) begin
      st_nxt.mk_hold = 1'b0;
    end else if (mkena_s && marker_s && !st_r.mk_d && !st_r.mk_hold) begin
      st_nxt.cnt = st_r.preset;
      st_nxt.mk_hold = 1'b1;
    end
    // host writes take effect at the access edge
    if (wr_acc && addr_ok) begin
      if (paddr == `PCC_OFS_CTRL) begin
        st_nxt.ctrl = pwdata[`PCC_CTL_W-1:0];
      end else if (paddr == `PCC_OFS_PRESET) begin
        st_nxt.preset = pwdata[`PCC_CNT_W-1:0];
      end else if (paddr == `PCC_OFS_COUNT) begin
        st_nxt.cnt = pwdata[`PCC_CNT_W-1:0];
      end else if (paddr == `PCC_OFS_CMP0) begin
        st_nxt.cmp_abc[0] = pwdata[`PCC_CNT_W-1:0];
      end else if (paddr == `PCC_OFS_CMP1) begin
        st_nxt.cmp_abc[1] = pwdata[`PCC_CNT_W-1:0];
      end else if (paddr == `PCC_OFS_CMP2) begin
        st_nxt.cmp_abc[2] = pwdata[`PCC_CNT_W-1:0];
      end else if (paddr >= `PCC_OFS_BREG && bidx < `PCC_NREG_B) begin
        st_nxt.cmp_b[bidx[3:0]] = pwdata[`PCC_CNT_W-1:0];
      end else if (paddr >= `PCC_OFS_PART && pidx < `PCC_NPART) begin
        st_nxt.part[pidx[4:0]] = pwdata[`PCC_OUT_W-1:0];
      end
    end
    // compare outputs recomputed from registered state each cycle
    if (st_r.ctrl[`PCC_CTL_MODE] == 1'(PCC_MODE_A)) begin
      st_nxt.cmp_o[0] = (st_r.cnt > st_r.cmp_abc[0]) ^ st_r.ctrl[`PCC_CTL_POLA];
      st_nxt.cmp_o[1] = (st_r.cnt > st_r.cmp_abc[1]) ^ st_r.ctrl[`PCC_CTL_POLB];
      st_nxt.cmp_o[2] = (st_r.cnt > st_r.cmp_abc[2]) ^ st_r.ctrl[`PCC_CTL_POLC];
      st_nxt.part_o = '0;
    end else begin
      st_nxt.cmp_o = '0;
      st_nxt.part_o = part_sel;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  assign compare_out_a_out = st_r.cmp_o[0];
  assign compare_out_b_out = st_r.cmp_o[1];
  assign compare_out_c_out = st_r.cmp_o[2];
  assign partition_out_out = st_r.part_o;
  assign marker_hold_out = st_r.mk_hold;
endmodule

// File: verification/pcc_top_asserts.sv
// assertion checker for the pulse counter comparator
`timescale 1ns/100ps
`include "pcc_cfg.svh"
module pcc_top_asserts (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCC_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic marker_in,
  input wire logic compare_out_a_out,
  input wire logic compare_out_b_out,
  input wire logic compare_out_c_out,
  input wire logic [`PCC_OUT_W-1:0] partition_out_out,
  input wire logic marker_hold_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire acc = psel && penable;
  wire wacc = acc && pwrite;
  wire [2:0] cmp = {compare_out_a_out, compare_out_b_out, compare_out_c_out};
  ////////////////////////////////////////
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_misal; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_misal: assert property (p_misal) else $error("misaligned not refused");
  property p_err_rd; acc && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_err_rd: assert property (p_err_rd) else $error("refused read data");
  property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_mode; |partition_out_out |-> cmp == 3'h0; endproperty
  a_mode: assert property (p_mode) else $error("both modes drive");
  property p_quiet;
    (!psel && !marker_in && $stable({phase_a_in, phase_b_in}))[*8]
      |=> $stable({cmp, partition_out_out});
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved idle");
  property p_hold_rise;
    $rose(marker_hold_out) |-> $past(marker_in, 1) || $past(marker_in, 2)
      || $past(marker_in, 3) || $past(marker_in, 4);
  endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("hold without marker");
  property p_hold_fall;
    $fell(marker_hold_out) |-> $past(wacc, 1) || $past(wacc, 2) || $past(wacc, 3);
  endproperty
  a_hold_fall: assert property (p_hold_fall) else $error("hold cleared alone");
  c_err: cover property (acc && pslverr);
  c_hold: cover property ($rose(marker_hold_out));
  c_part: cover property (|partition_out_out);
endmodule
bind pcc_top pcc_top_asserts pcc_top_asserts_inst (.*);

// File: verification/pcc_pulse_gen.sv
// quadrature pulse generator model, one edge per step
`timescale 1ns/100ps
module pcc_pulse_gen (
  input wire logic ref_clk_in,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic pm_in,
  output logic phase_a_out,
  output logic phase_b_out
);
  logic [1:0] ph_r = 2'h0;
  logic up_r = 1'b0;
  logic dn_r = 1'b0;
  always @(posedge ref_clk_in) begin
    if (step_in) ph_r <= dir_in ? ph_r - 2'h1 : ph_r + 2'h1;
    up_r <= step_in & ~dir_in;
    dn_r <= step_in & dir_in;
  end
  // quadrature: phase a leads when stepping up
  // pulse mode: one up or down pulse per step
  assign phase_a_out = pm_in ? up_r : ph_r[1] ^ ph_r[0];
  assign phase_b_out = pm_in ? dn_r : ph_r[1];
endmodule

// File: verification/pulse_counter_comparator_tb.sv
// testbench for the pulse counter comparator
`timescale 1ns/100ps
`include "pcc_cfg.svh"
module pulse_counter_comparator_tb;
  logic ref_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr, se, stp, dir, pm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic phase_a_in, phase_b_in, marker_in, marker_enable_contact_in, count_stop_contact_in;
  logic compare_out_a_out, compare_out_b_out, compare_out_c_out, marker_hold_out;
  logic [7:0] partition_out_out;
  int error_cnt, checks_done, cyc, e;
  int cv[5] = '{0, 10, 11, 160, 161};
  pcc_top pcc_top_inst (.*);
  pcc_pulse_gen pcc_pulse_gen_inst (.ref_clk_in(ref_clk_in), .step_in(stp), .dir_in(dir),
    .pm_in(pm), .phase_a_out(phase_a_in), .phase_b_out(phase_b_in));
  ////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1) @(posedge ref_clk_in);
    se = pslverr;
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic w8();
    repeat (8) @(posedge ref_clk_in);
  endtask
  task automatic mv(input int n, input logic d);
    dir <= d;
    repeat (n) begin
      stp <= 1'b1;
      @(posedge ref_clk_in);
      stp <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
    end
    w8();
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {rstn_in, psel, penable, pwrite, stp, dir, marker_in, pm} = 8'h0;
    {marker_enable_contact_in, count_stop_contact_in, paddr, pwdata} = 46'h0;
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    xf(1'b1, `PCC_OFS_COUNT, 32'h64);
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h64);
    xf(1'b1, `PCC_OFS_CMP0, 32'h63);
    xf(1'b1, `PCC_OFS_CMP1, 32'h64);
    xf(1'b1, `PCC_OFS_CMP2, 32'h65);
    w8();
    chk({compare_out_a_out, compare_out_b_out, compare_out_c_out}, 32'h4);
    xf(1'b1, `PCC_OFS_CTRL, 32'hE);
    w8();
    chk({compare_out_a_out, compare_out_b_out, compare_out_c_out}, 32'h3);
    mv(8, 1'b0);
    chk({compare_out_a_out, compare_out_b_out, compare_out_c_out}, 32'h0);
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h6C);
    mv(8, 1'b1);
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h64);
    count_stop_contact_in <= 1'b1;
    w8();
    mv(4, 1'b0);
    count_stop_contact_in <= 1'b0;
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h64);
    xf(1'b1, `PCC_OFS_COUNT, 32'h0);
    mv(1, 1'b1);
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h7FFFFF);
    xf(1'b1, `PCC_OFS_PRESET, 32'h1234);
    xf(1'b1, `PCC_OFS_CTRL, 32'h10);
    marker_enable_contact_in <= 1'b1;
    marker_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    marker_in <= 1'b0;
    w8();
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h1234);
    chk(marker_hold_out, 32'h1);
    xf(1'b1, `PCC_OFS_CTRL, 32'h0);
    w8();
    chk(marker_hold_out, 32'h0);
    xf(1'b0, 12'hFFC, 32'h0);
    chk(se, 32'h1);
    chk(rv, 32'h0);
    for (int n = 0; n < 16; n++) xf(1'b1, `PCC_OFS_BREG + 12'(4*n), 32'(10*n+10));
    for (int n = 0; n < 17; n++) xf(1'b1, `PCC_OFS_PART + 12'(4*n), 32'(n+1));
    xf(1'b1, `PCC_OFS_CTRL, 32'h1);
    foreach (cv[i]) begin
      xf(1'b1, `PCC_OFS_COUNT, cv[i]);
      w8();
      e = 16;
      for (int n = 15; n >= 0; n--) if (10*n+10 >= cv[i]) e = n;
      chk(partition_out_out, 32'(e+1));
      chk({compare_out_a_out, compare_out_b_out, compare_out_c_out}, 32'h0);
    end
    xf(1'b1, `PCC_OFS_CTRL, 32'h20);
    pm <= 1'b1;
    w8();
    xf(1'b1, `PCC_OFS_COUNT, 32'h0);
    mv(3, 1'b0);
    mv(1, 1'b1);
    xf(1'b0, `PCC_OFS_COUNT, 32'h0);
    chk(rv, 32'h2);
    chk({compare_out_a_out, compare_out_b_out, compare_out_c_out}, 32'h0);
    close_out();
  end
endmodule
